// ### src/lfs_defs.vh
// Purpose: Constants for the LCD frame-memory scan-out block.
// Assumes: 125 MHz system clock, 32x48 dot panel plus one icon common.
// Notes:   Level codes index the six bias voltages, V0 lowest.
`ifndef LFS_DEFS_VH
`define LFS_DEFS_VH

// ----------------------------------------------------------------------
// Panel geometry
// ----------------------------------------------------------------------
`define LFS_ROWS 32
`define LFS_COLS 48
`define LFS_COMS 33
`define LFS_ICONS 4
`define LFS_BYTES_PER_ROW 6
`define LFS_BANK_ROWS 16
`define LFS_ICON_ROW 6'h20

// ----------------------------------------------------------------------
// Frame memory layout (flat byte address = bank base + offset)
// ----------------------------------------------------------------------
`define LFS_BANK_BYTES 8'h60
`define LFS_ICON_BYTES 8'h06
`define LFS_BANK0_BASE 8'h00
`define LFS_BANK1_BASE 8'h60
`define LFS_BANK2_BASE 8'hC0
`define LFS_MEM_DEPTH 198
`define LFS_BANK_ICON 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LFS_SYS_CLK_HZ 125000000
`define LFS_REFRESH_HZ 1000
`define LFS_SLOT_CYC (`LFS_SYS_CLK_HZ / (`LFS_REFRESH_HZ * `LFS_COMS))

// ----------------------------------------------------------------------
// One-fifth bias drive level codes
// ----------------------------------------------------------------------
`define LFS_LVL_V0 3'h0
`define LFS_LVL_V1 3'h1
`define LFS_LVL_V2 3'h2
`define LFS_LVL_V3 3'h3
`define LFS_LVL_V4 3'h4
`define LFS_LVL_V5 3'h5

`endif

// ### src/lfs_frame_mem.v
// Purpose: Byte-wide display frame memory, one write and one read port.
// Assumes: Caller gives flat byte addresses below DEPTH.
// Notes:   No reset on the array, so contents survive sleep and reset.
`timescale 1ns/1ps
`default_nettype none

module lfs_frame_mem #(
  parameter DEPTH = 198,
  parameter AW = 8
) (
  input wire i_clk_sys,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [7:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [7:0] o_rdata
);

  reg [7:0] mem [0:DEPTH-1];

  // Write and registered read; read of a same-cycle write sees old data
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

`default_nettype wire

// ### src/lfs_scanout.v
// Purpose: Scan a bit-mapped frame memory onto a 32x48 dot LCD with icons.
// Assumes: Write port and control inputs come from logic on i_clk_sys.
// Notes:   One line latch only; memory writes show on the next refresh.
//
// Overview of operation
// R1: Drive 32 rows by 48 columns of dots plus four mode icons.
// R2: Three banks; banks 0 and 1 image, bank 2 icons for system only.
// R3: Bank 0 feeds upper sixteen rows, bank 1 lower sixteen rows.
// R4: One bit per dot, byte is eight adjacent dots, six bytes a row.
// R5: A one bit darkens its dot, a zero bit leaves it clear.
// R6: New memory contents appear next refresh, no frame buffer or swap.
// R7: Only panel on/off control; no contrast, brightness or backlight.
// R8: Sleep switches drive off while memory contents are kept.
// R9: Commons multiplexed at 1/33 duty with 1/5 bias levels.
// R10: Byte MSB is leftmost dot; rows scan top of bank 0 to bottom of bank 1.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_defs.vh"

module lfs_scanout #(
  parameter SLOT_CYC = `LFS_SLOT_CYC,
  parameter MEM_DEPTH = `LFS_MEM_DEPTH
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_mem_we,
  input wire [1:0] i_mem_bank,
  input wire [6:0] i_mem_offset,
  input wire [7:0] i_mem_wdata,
  input wire i_mem_sys,
  input wire i_panel_on,
  input wire i_sleep,
  output reg o_drive_on,
  output reg o_frame_pol,
  output reg [`LFS_COMS*3-1:0] o_com_level,
  output reg [`LFS_COLS*3-1:0] o_seg_level
);

  // ----------------------------------------------------------------------
  // Constants and functions
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_FETCH = 2'b10;
  localparam integer SLOT_LAST_I = SLOT_CYC - 1;
  localparam [11:0] SLOT_LAST = SLOT_LAST_I[11:0];

  // Bias level for a segment or common; pol flips every frame for AC drive
  function [2:0] lfs_level;
    input is_com;
    input active;
    input pol;
    begin
      if (is_com) begin
        if (active) begin
          lfs_level = pol ? `LFS_LVL_V5 : `LFS_LVL_V0;
        end else begin
          lfs_level = pol ? `LFS_LVL_V1 : `LFS_LVL_V4;
        end
      end else begin
        if (active) begin
          lfs_level = pol ? `LFS_LVL_V0 : `LFS_LVL_V5;
        end else begin
          lfs_level = pol ? `LFS_LVL_V2 : `LFS_LVL_V3;
        end
      end
    end
  endfunction

  // Flat byte address of byte b of a scan row
  function [7:0] lfs_row_addr;
    input [5:0] row;
    input [2:0] b;
    reg [7:0] base;
    begin
      base = 8'h00;
      if (row == `LFS_ICON_ROW) begin
        base = `LFS_BANK2_BASE;
      end else if (row < `LFS_BANK_ROWS) begin
        base = `LFS_BANK0_BASE + {4'h0, row[3:0]} * 8'h06;
      end else begin
        base = `LFS_BANK1_BASE + {4'h0, row[3:0]} * 8'h06;
      end
      lfs_row_addr = base + {5'h00, b};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Write port: application may reach banks 0 and 1 only
  // ----------------------------------------------------------------------
  reg wr_ok;
  reg [7:0] wr_addr;

  always @* begin
    wr_ok = 1'b0;
    wr_addr = 8'h00;
    if (i_mem_bank == 2'h0) begin
      wr_ok = ({1'b0, i_mem_offset} < `LFS_BANK_BYTES); // [R2] [R3]
      wr_addr = `LFS_BANK0_BASE + {1'b0, i_mem_offset};
    end else if (i_mem_bank == 2'h1) begin
      wr_ok = ({1'b0, i_mem_offset} < `LFS_BANK_BYTES); // [R3]
      wr_addr = `LFS_BANK1_BASE + {1'b0, i_mem_offset};
    end else if (i_mem_bank == `LFS_BANK_ICON) begin
      // Icon bank is system territory
      wr_ok = i_mem_sys &&
        ({1'b0, i_mem_offset} < `LFS_ICON_BYTES); // [R2]
      wr_addr = `LFS_BANK2_BASE + {1'b0, i_mem_offset};
    end
  end

  // ----------------------------------------------------------------------
  // Memory; writes continue in sleep, nothing clears it
  // ----------------------------------------------------------------------
  reg [7:0] rd_addr_reg;
  wire [7:0] rd_data;

  lfs_frame_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(8)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(i_mem_we && wr_ok), // [R8]
    .i_waddr(wr_addr),
    .i_wdata(i_mem_wdata),
    .i_raddr(rd_addr_reg),
    .o_rdata(rd_data)
  );

  // ----------------------------------------------------------------------
  // Slot timer: 33 common slots per frame
  // ----------------------------------------------------------------------
  reg [11:0] slot_cnt_reg;
  wire slot_tick = (slot_cnt_reg == SLOT_LAST);

  always @(posedge i_clk_sys) begin
    if (i_sys_rst || slot_tick) begin
      slot_cnt_reg <= 12'h000;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 12'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Row fetch: read six bytes of the next row into the line latch
  // ----------------------------------------------------------------------
  reg [1:0] state_reg;
  reg [5:0] fetch_row_reg;
  reg [2:0] byte_reg;
  reg rd_pend_reg;
  reg [2:0] rd_byte_reg;
  reg rd_pend2_reg;
  reg [2:0] rd_byte2_reg;
  reg [`LFS_COLS-1:0] line_reg;
  reg [5:0] line_row_reg;
  integer k;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_reg <= ST_FETCH;
      fetch_row_reg <= 6'h00;
      byte_reg <= 3'h0;
      rd_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_byte_reg <= 3'h0;
      rd_pend2_reg <= 1'b0;
      rd_byte2_reg <= 3'h0;
      line_reg <= {`LFS_COLS{1'b0}};
      line_row_reg <= 6'h00;
    end else begin
      rd_pend_reg <= 1'b0;
      rd_pend2_reg <= rd_pend_reg;
      rd_byte2_reg <= rd_byte_reg;
      // Capture two cycles after the address: memory output is registered
      if (rd_pend2_reg) begin
        for (k = 0; k < 8; k = k + 1) begin
          line_reg[rd_byte2_reg*8 + k] <= rd_data[7-k]; // [R4] [R10]
        end
      end
      case (state_reg)
        ST_FETCH: begin
          rd_addr_reg <= lfs_row_addr(fetch_row_reg, byte_reg); // [R3]
          rd_pend_reg <= 1'b1;
          rd_byte_reg <= byte_reg;
          if (byte_reg == 3'h5) begin
            byte_reg <= 3'h0;
            line_row_reg <= fetch_row_reg;
            state_reg <= ST_IDLE;
          end else begin
            byte_reg <= byte_reg + 3'h1;
          end
        end
        default: begin
          // Fetch of next row starts as the current one is shown,
          // so a write lands on screen within one frame
          if (slot_tick) begin
            if (fetch_row_reg == `LFS_ICON_ROW) begin
              fetch_row_reg <= 6'h00; // [R10]
            end else begin
              fetch_row_reg <= fetch_row_reg + 6'h01;
            end
            state_reg <= ST_FETCH; // [R6]
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Drive outputs, updated at each slot boundary
  // ----------------------------------------------------------------------
  wire drive_en = i_panel_on && !i_sleep; // [R7] [R8]
  reg [`LFS_COMS*3-1:0] com_next;
  reg [`LFS_COLS*3-1:0] seg_next;
  reg pol_next;
  genvar g;

  always @* begin
    pol_next = o_frame_pol;
    if (line_row_reg == 6'h00) begin
      pol_next = ~o_frame_pol;
    end
  end

  // One selected common per slot gives 1/33 duty
  generate
    for (g = 0; g < `LFS_COMS; g = g + 1) begin : g_com
      always @* begin
        com_next[g*3 +: 3] = lfs_level(1'b1,
          (line_row_reg == g), pol_next); // [R9] [R1]
      end
    end
    for (g = 0; g < `LFS_COLS; g = g + 1) begin : g_seg
      always @* begin
        if (line_row_reg == `LFS_ICON_ROW && g >= `LFS_ICONS) begin
          // Only the four icon segments exist on the icon common
          seg_next[g*3 +: 3] = lfs_level(1'b0, 1'b0, pol_next); // [R1]
        end else begin
          seg_next[g*3 +: 3] = lfs_level(1'b0,
            line_reg[g], pol_next); // [R5] [R9]
        end
      end
    end
  endgenerate

  // Off state parks every line at V0 so no DC stress reaches the glass
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_drive_on <= 1'b0;
      o_frame_pol <= 1'b0;
      o_com_level <= {`LFS_COMS*3{1'b0}};
      o_seg_level <= {`LFS_COLS*3{1'b0}};
    end else if (!drive_en) begin
      o_drive_on <= 1'b0; // [R7] [R8]
      o_com_level <= {`LFS_COMS*3{1'b0}};
      o_seg_level <= {`LFS_COLS*3{1'b0}};
    end else if (slot_tick) begin
      o_drive_on <= 1'b1;
      o_frame_pol <= pol_next;
      o_com_level <= com_next; // [R9]
      o_seg_level <= seg_next;
    end
  end

endmodule

`default_nettype wire

// ### dv/lfs_panel_model.sv
// Purpose: Panel model that turns drive levels back into one dot row.
// Assumes: Level codes per polarity as the scan-out drives them.
// Notes:   Pure decode; panel optics and lag are not modelled.
`timescale 1ns/1ps
`default_nettype none
module lfs_panel_model (
  input wire logic i_frame_pol,
  input wire logic [98:0] i_com_level,
  input wire logic [143:0] i_seg_level,
  output logic [5:0] o_row,
  output logic [47:0] o_dots
);
  // Common at select level picks the row; 3F means none found
  always_comb begin
    o_row = 6'h3F;
    for (int k = 32; k >= 0; k--) begin
      if (i_com_level[k*3+:3] == (i_frame_pol ? 3'h5 : 3'h0)) begin
        o_row = 6'(k);
      end
    end
  end
  // Segment at the far level from the common darkens its dot
  always_comb begin
    for (int s = 0; s < 48; s++) begin
      o_dots[s] = i_seg_level[s*3+:3] == (i_frame_pol ? 3'h0 : 3'h5);
    end
  end
endmodule
`default_nettype wire

// ### dv/lfs_checker.sv
// Purpose: Port assertions for the scan-out block.
// Assumes: SLOT_CYC equals the instance value.
// Notes:   Slot length is tracked by a counter, too long to unroll.
`timescale 1ns/1ps
`default_nettype none
module lfs_checker #(parameter SLOT_CYC = 16) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_panel_on,
  input wire logic i_sleep,
  input wire logic o_drive_on,
  input wire logic o_frame_pol,
  input wire logic [98:0] o_com_level,
  input wire logic [143:0] o_seg_level
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic [5:0] sel_idx;
  logic [5:0] n_sel;
  logic [5:0] n_uns;
  logic seg_ok;
  logic [98:0] prev_com;
  logic [15:0] cnt_reg;
  // Decode selected common and legality of every segment level
  always_comb begin
    sel_idx = 6'h3F;
    n_sel = 6'h00;
    n_uns = 6'h00;
    seg_ok = 1'b1;
    for (int k = 0; k < 33; k++) begin
      if (o_com_level[k*3+:3] == (o_frame_pol ? 3'h5 : 3'h0)) begin
        sel_idx = 6'(k);
        n_sel++;
      end
      if (o_com_level[k*3+:3] == (o_frame_pol ? 3'h1 : 3'h4)) n_uns++;
    end
    for (int s = 0; s < 48; s++) begin
      if (o_seg_level[s*3+:3] != (o_frame_pol ? 3'h2 : 3'h3) &&
          ((s >= 4 && sel_idx == 6'h20) ||
           o_seg_level[s*3+:3] != (o_frame_pol ? 3'h0 : 3'h5)))
        seg_ok = 1'b0;
    end
  end
  // Cycles since the commons last moved
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      prev_com <= '0;
      cnt_reg <= '0;
    end else begin
      prev_com <= o_com_level;
      cnt_reg <= (o_com_level != prev_com) ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end
  property p_off; !o_drive_on |-> o_com_level == '0 && o_seg_level == '0;
  endproperty
  a_off: assert property (p_off) else $error("drive off, levels not zero");
  property p_sleep; i_sleep |=> !o_drive_on; endproperty
  a_sleep: assert property (p_sleep) else $error("drive on in sleep");
  property p_panel; !i_panel_on |=> !o_drive_on; endproperty
  a_panel: assert property (p_panel) else $error("drive on, panel off");
  property p_one; o_drive_on |-> n_sel == 6'h01 && n_uns == 6'h20; endproperty
  a_one: assert property (p_one) else $error("common levels wrong");
  property p_seg; o_drive_on |-> seg_ok; endproperty
  a_seg: assert property (p_seg) else $error("segment level wrong");
  property p_slot; o_drive_on && $past(o_drive_on) && o_com_level != prev_com
    |-> cnt_reg == 16'(SLOT_CYC - 1); endproperty
  a_slot: assert property (p_slot) else $error("slot length wrong");
  property p_order; o_drive_on && $past(o_drive_on) && $changed(sel_idx)
    |-> sel_idx == ($past(sel_idx) == 6'h20 ? 6'h00 : $past(sel_idx) + 6'h01);
  endproperty
  a_order: assert property (p_order) else $error("row order wrong");
  property p_pol; o_drive_on && $past(o_drive_on) |->
    $changed(o_frame_pol) == ($changed(sel_idx) && sel_idx == 6'h00); endproperty
  a_pol: assert property (p_pol) else $error("polarity flip wrong");
  c_icon: cover property (o_drive_on && sel_idx == 6'h20);
  c_off: cover property ($fell(o_drive_on));
  c_pol: cover property ($rose(o_frame_pol));
endmodule
bind lfs_scanout lfs_checker #(.SLOT_CYC(SLOT_CYC)) lfs_checker_i (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_panel_on(i_panel_on),
  .i_sleep(i_sleep), .o_drive_on(o_drive_on), .o_frame_pol(o_frame_pol),
  .o_com_level(o_com_level), .o_seg_level(o_seg_level));
`default_nettype wire

// ### dv/lfs_scanout_bench.sv
// Purpose: Self-checking bench for the frame memory scan-out.
// Assumes: Short slot of 16 cycles; inputs change at falling edges.
// Notes:   A shadow copy of the memory predicts every shown row.
`timescale 1ns/1ps
`default_nettype none
module lfs_scanout_bench;
  localparam int SLOT = 16;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_mem_we = 1'b0;
  logic [1:0] i_mem_bank = 2'h0;
  logic [6:0] i_mem_offset = 7'h00;
  logic [7:0] i_mem_wdata = 8'h00;
  logic i_mem_sys = 1'b0;
  logic i_panel_on = 1'b1;
  logic i_sleep = 1'b0;
  wire o_drive_on;
  wire o_frame_pol;
  wire [98:0] o_com_level;
  wire [143:0] o_seg_level;
  wire [5:0] row;
  wire [47:0] dots;
  logic [7:0] shd [0:191];
  logic [7:0] icon_reg;
  logic [31:0] rnd = 32'h00006ED8;
  int failures = 0;
  int samples_checked = 0;
  lfs_scanout #(.SLOT_CYC(SLOT)) lfs_scanout_i (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_mem_we(i_mem_we), .i_mem_bank(i_mem_bank),
    .i_mem_offset(i_mem_offset), .i_mem_wdata(i_mem_wdata),
    .i_mem_sys(i_mem_sys), .i_panel_on(i_panel_on), .i_sleep(i_sleep),
    .o_drive_on(o_drive_on), .o_frame_pol(o_frame_pol),
    .o_com_level(o_com_level), .o_seg_level(o_seg_level));
  lfs_panel_model lfs_panel_model_i (.i_frame_pol(o_frame_pol),
    .i_com_level(o_com_level), .i_seg_level(o_seg_level), .o_row(row),
    .o_dots(dots));
  initial begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Expected dots of one row from the shadow, MSB leftmost
  function automatic logic [47:0] exp_row(input int r);
    logic [47:0] d;
    d = '0;
    for (int c = 0; c < 48; c++) begin
      if (r < 32) d[c] = shd[r*6 + c/8][7 - c%8];
      else if (c < 4) d[c] = icon_reg[7 - c];
    end
    return d;
  endfunction
  task automatic print_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_dots(input logic [47:0] e, input logic [47:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch dots exp %h got %h", e, s);
    end
  endtask
  task automatic cmp_val(input string n, input logic [5:0] e,
                         input logic [5:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  // Write held until the next falling edge; refused ones leave shadow
  task automatic wr(input logic [1:0] b, input logic [6:0] o,
                    input logic [7:0] d, input logic s);
    @(negedge i_clk_sys);
    i_mem_we = 1'b1;
    i_mem_bank = b;
    i_mem_offset = o;
    i_mem_wdata = d;
    i_mem_sys = s;
    if (b < 2 && o < 96) shd[b*96 + o] = d;
    if (b == 2 && s && o == 0) icon_reg = d;
  endtask
  task automatic idle;
    @(negedge i_clk_sys);
    i_mem_we = 1'b0;
  endtask
  task automatic wait_row(input logic [5:0] r);
    int n;
    n = 0;
    while (row !== r) begin
      @(negedge i_clk_sys);
      n++;
      if (n > 700) begin
        cmp_val("wait row", r, row);
        print_verdict();
      end
    end
  endtask
  // One whole frame compared slot by slot
  task automatic check_frame;
    wait_row(6'h01);
    wait_row(6'h00);
    for (int r = 0; r < 33; r++) begin
      cmp_val("row", 6'(r), row);
      cmp_val("drive", 6'h01, {5'h00, o_drive_on});
      cmp_dots(exp_row(r), dots);
      repeat (SLOT) @(negedge i_clk_sys);
    end
  endtask
  initial begin
    repeat (16) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    for (int a = 0; a < 192; a++) begin
      rnd = xs(rnd);
      wr(2'(a / 96), 7'(a % 96), rnd[7:0], 1'b0);
    end
    wr(2'h0, 7'h00, 8'h80, 1'b0);
    wr(2'h1, 7'h5F, 8'h01, 1'b0);
    wr(2'h2, 7'h00, 8'hA0, 1'b1);
    wr(2'h3, 7'h00, 8'hFF, 1'b1);
    wr(2'h0, 7'h60, 8'hFF, 1'b0);
    wr(2'h2, 7'h00, 8'h50, 1'b0);
    idle();
    check_frame();
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      wr(2'h1, 7'(rnd[15:8] % 96), rnd[7:0], 1'b0);
    end
    idle();
    check_frame();
    i_panel_on = 1'b0;
    repeat (40) @(negedge i_clk_sys);
    cmp_val("drive", 6'h00, {5'h00, o_drive_on});
    i_panel_on = 1'b1;
    i_sleep = 1'b1;
    wr(2'h1, 7'h0A, 8'h3C, 1'b0);
    idle();
    repeat (40) @(negedge i_clk_sys);
    cmp_val("drive", 6'h00, {5'h00, o_drive_on});
    i_sleep = 1'b0;
    check_frame();
    i_sys_rst = 1'b1;
    repeat (16) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    check_frame();
    print_verdict();
  end
endmodule
`default_nettype wire
